/* File: design/tx_queue_pkg.sv */
// Package with register map, descriptor layout and states of the transmit descriptor queue.
// Behaviour
// [RULE1] Host writes the completion pointer with the last descriptor it has processed.
// [RULE2] Port compares the completion pointer with its progress to drop the interrupt.
// [RULE3] Descriptor word zero is the word-aligned address of the next descriptor.
// [RULE4] A zero next address marks the last descriptor; nothing more is fetched.
// [RULE5] Host fills next and payload addresses before handing a descriptor over.
// [RULE6] Payload address is byte aligned and passed on unchanged.
// [RULE7] First-segment and last-segment flags are always one in every descriptor.
// [RULE8] Ownership one means port owned; port clears it after sending the message.
// [RULE9] Ownership is interpreted only when the first-segment flag is set.
// [RULE10] Host reclaims a buffer only after the port cleared its ownership flag.
// [RULE11] On a last descriptor with zero next address the queue-drained flag is set; the code leaves it zero on a teardown write-back.
// [RULE12] Queue-drained flag stays zero while further messages remain queued.
// [RULE13] Teardown-done flag is written as one once a commanded teardown finishes.
// [RULE14] Host starts by writing the head pointer; port zeroes it when all are sent.
// [RULE15] Writing the head pointer while it is nonzero raises an error.
// [RULE16] A descriptor is four contiguous 32-bit words on a 32-bit boundary.
// [RULE17] On teardown the outcome code is written as 110 with the teardown flag.
// [RULE18] Word three flags sit at bits 31 to 27; word two holds routing fields.
// [RULE19] Descriptors are handled in chain order, each released before the next fetch.
package tx_queue_pkg;
    localparam logic [11:0] HEAD_PTR_OFS = 12'h500;
    localparam logic [11:0] DONE_PTR_OFS = 12'h058;
    localparam logic [31:0] PTR_RESET = 32'h0000_0000;
    localparam logic [3:0] WORD_BYTES = 4'h4;
    localparam logic [1:0] LAST_WORD = 2'h3;
    localparam logic [2:0] OUTCOME_GOOD = 3'h0;
    localparam logic [2:0] OUTCOME_TEARDOWN = 3'h6;

    typedef struct packed {
        logic sop;
        logic eop;
        logic owner;
        logic drained;
        logic tdown;
        logic [6:0] rsvd;
        logic [2:0] outcome_code;
        logic [8:0] retry_count;
        logic [7:0] msg_len;
    } word3_t;

    typedef struct packed {
        logic [31:0] buf_addr;
        logic [31:0] route;
        logic [7:0] msg_len;
    } tx_msg_t;

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_FETCH = 5'h02,
        S_SEND = 5'h04,
        S_WAIT = 5'h08,
        S_BACK = 5'h10
    } state_t;
endpackage

/* File: design/tx_message_descriptor_queue.sv */
// Transmit descriptor queue engine: walks the chain, sends messages and writes status back.
`timescale 1ns/1ps
module tx_message_descriptor_queue (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_reg_wr,
    input wire logic [11:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    output logic [31:0] o_reg_rdata,
    input wire logic i_teardown,
    output logic o_head_write_err,
    output logic o_teardown_done,
    output logic o_tx_irq,
    output logic o_mem_req,
    output logic o_mem_we,
    output logic [31:0] o_mem_addr,
    output logic [31:0] o_mem_wdata,
    input wire logic i_mem_ack,
    input wire logic [31:0] i_mem_rdata,
    output logic o_tx_valid,
    output tx_queue_pkg::tx_msg_t o_tx_msg,
    input wire logic i_tx_ready,
    input wire logic i_tx_done
);
    tx_queue_pkg::state_t state;
    tx_queue_pkg::state_t next_state;
    logic [31:0] head_ptr;
    logic [31:0] done_ptr;
    logic [31:0] cur_ptr;
    logic [31:0] next_ptr;
    logic [31:0] last_done;
    logic [1:0] widx;
    logic td_pend;
    logic td_now;
    logic irq;
    tx_queue_pkg::word3_t word3;

    wire head_wr = i_reg_wr && (i_reg_addr == tx_queue_pkg::HEAD_PTR_OFS);
    wire done_wr = i_reg_wr && (i_reg_addr == tx_queue_pkg::DONE_PTR_OFS);
    wire head_busy = (head_ptr != tx_queue_pkg::PTR_RESET);
    wire fetch_ack = (state == tx_queue_pkg::S_FETCH) && i_mem_ack;
    wire last_word = fetch_ack && (widx == tx_queue_pkg::LAST_WORD);
    wire back_ack = (state == tx_queue_pkg::S_BACK) && i_mem_ack;
    wire chain_end = (next_ptr == tx_queue_pkg::PTR_RESET);
    wire [31:0] desc_base = {cur_ptr[31:2], 2'b00};
    tx_queue_pkg::word3_t rd_w3;
    assign rd_w3 = tx_queue_pkg::word3_t'(i_mem_rdata);
    // Ownership only counts on a first-segment descriptor; others are never sent.
    wire port_owned = rd_w3.sop && rd_w3.owner; // [RULE9]
    wire stop_walk = td_now || chain_end; // [RULE4]

    tx_queue_pkg::word3_t wb_w3;
    always_comb begin
        wb_w3 = word3;
        wb_w3.sop = 1'b1; // [RULE7]
        wb_w3.eop = 1'b1; // [RULE7]
        wb_w3.owner = 1'b0; // [RULE8]
        wb_w3.drained = chain_end && !td_now; // [RULE11] [RULE12]
        wb_w3.tdown = td_now; // [RULE13]
        wb_w3.outcome_code = td_now ? tx_queue_pkg::OUTCOME_TEARDOWN
                                    : tx_queue_pkg::OUTCOME_GOOD; // [RULE17]
    end

    always_comb begin
        next_state = state;
        unique case (state)
            tx_queue_pkg::S_IDLE: begin
                if (head_busy) begin
                    next_state = tx_queue_pkg::S_FETCH;
                end
            end
            tx_queue_pkg::S_FETCH: begin
                if (last_word) begin
                    if (td_pend) begin
                        next_state = tx_queue_pkg::S_BACK;
                    end else if (port_owned) begin
                        next_state = tx_queue_pkg::S_SEND;
                    end else begin
                        next_state = tx_queue_pkg::S_IDLE;
                    end
                end
            end
            tx_queue_pkg::S_SEND: begin
                if (i_tx_ready) begin
                    next_state = tx_queue_pkg::S_WAIT;
                end
            end
            tx_queue_pkg::S_WAIT: begin
                if (i_tx_done) begin
                    next_state = tx_queue_pkg::S_BACK;
                end
            end
            tx_queue_pkg::S_BACK: begin
                if (i_mem_ack) begin
                    // The next fetch starts only after this descriptor is released.
                    next_state = stop_walk ? tx_queue_pkg::S_IDLE
                                           : tx_queue_pkg::S_FETCH; // [RULE19]
                end
            end
        endcase
    end

    // Descriptor words are fetched from the aligned base, one word per access.
    assign o_mem_req = (state == tx_queue_pkg::S_FETCH) || (state == tx_queue_pkg::S_BACK);
    assign o_mem_we = (state == tx_queue_pkg::S_BACK);
    wire [1:0] word_sel = o_mem_we ? tx_queue_pkg::LAST_WORD : widx;
    wire [31:0] word_ofs = {28'h0, tx_queue_pkg::WORD_BYTES} * {30'h0, word_sel};
    assign o_mem_addr = desc_base + word_ofs; // [RULE16]
    assign o_mem_wdata = wb_w3;
    assign o_tx_valid = (state == tx_queue_pkg::S_SEND);
    assign o_tx_irq = irq;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= tx_queue_pkg::S_IDLE;
            widx <= 2'h0;
            cur_ptr <= 32'h0;
            next_ptr <= 32'h0;
            word3 <= '0;
            o_tx_msg <= '0;
            td_now <= 1'b0;
        end else begin
            state <= next_state;
            if (state == tx_queue_pkg::S_IDLE && head_busy) begin
                cur_ptr <= head_ptr;
                widx <= 2'h0;
            end
            if (fetch_ack) begin
                widx <= widx + 2'h1;
                td_now <= td_pend;
                unique case (widx)
                    2'h0: next_ptr <= i_mem_rdata; // [RULE3]
                    2'h1: o_tx_msg.buf_addr <= i_mem_rdata; // [RULE6]
                    2'h2: o_tx_msg.route <= i_mem_rdata; // [RULE18]
                    2'h3: begin
                        word3 <= rd_w3; // [RULE18]
                        o_tx_msg.msg_len <= rd_w3.msg_len;
                    end
                endcase
            end
            if (back_ack && !stop_walk) begin
                cur_ptr <= next_ptr; // [RULE3]
                widx <= 2'h0;
            end
        end
    end

    // Head pointer, completion pointer, interrupt and teardown bookkeeping.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            head_ptr <= tx_queue_pkg::PTR_RESET;
            done_ptr <= tx_queue_pkg::PTR_RESET;
            last_done <= tx_queue_pkg::PTR_RESET;
            irq <= 1'b0;
            td_pend <= 1'b0;
            o_head_write_err <= 1'b0;
            o_teardown_done <= 1'b0;
            o_reg_rdata <= 32'h0;
        end else begin
            o_head_write_err <= head_wr && head_busy; // [RULE15]
            o_teardown_done <= back_ack && td_now; // [RULE13]
            if (head_wr && !head_busy) begin
                head_ptr <= i_reg_wdata; // [RULE14]
            end
            if (done_wr) begin
                done_ptr <= i_reg_wdata;
            end
            // The new completion wins over a stale acknowledge in the same cycle.
            if (back_ack) begin
                irq <= 1'b1;
                last_done <= desc_base;
                head_ptr <= stop_walk ? tx_queue_pkg::PTR_RESET : next_ptr; // [RULE14]
            end else if (done_wr && (i_reg_wdata == last_done)) begin
                irq <= 1'b0; // [RULE2]
            end
            if (i_teardown) begin
                td_pend <= 1'b1;
            end else if (back_ack && td_now) begin
                td_pend <= 1'b0;
            end else if (state == tx_queue_pkg::S_IDLE && !head_busy) begin
                td_pend <= 1'b0;
            end
            if (state == tx_queue_pkg::S_FETCH && last_word && !td_pend && !port_owned) begin
                head_ptr <= tx_queue_pkg::PTR_RESET;
            end
            o_reg_rdata <= (i_reg_addr == tx_queue_pkg::HEAD_PTR_OFS) ? head_ptr
                         : (i_reg_addr == tx_queue_pkg::DONE_PTR_OFS) ? done_ptr : 32'h0;
        end
    end

    a_wb_owner_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        o_mem_we |-> !o_mem_wdata[29] && o_mem_wdata[31] && o_mem_wdata[30]) // [RULE8]
        else $error("Write-back keeps ownership or drops segment flags.");
    a_wb_drained: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        o_mem_we && !td_now |-> o_mem_wdata[28] == chain_end) // [RULE11]
        else $error("Queue-drained flag does not match chain end.");
    a_wb_teardown: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        o_mem_we && td_now |-> o_mem_wdata[27] && o_mem_wdata[19:17] == 3'h6) // [RULE17]
        else $error("Teardown write-back lacks flag or outcome code.");
    a_head_zeroed: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        back_ack && chain_end |=> head_ptr == 32'h0 && state == tx_queue_pkg::S_IDLE) // [RULE4]
        else $error("Head pointer not cleared at end of queue.");
    a_head_error: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        head_wr && head_busy |=> o_head_write_err
            && ($stable(head_ptr) || $past(back_ack || last_word))) // [RULE15]
        else $error("Busy head pointer write not flagged.");
    a_irq_raise: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        back_ack |=> o_tx_irq) // [RULE2]
        else $error("Interrupt not raised after completion.");
    a_irq_ack: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        done_wr && !back_ack && i_reg_wdata == last_done |=> !o_tx_irq) // [RULE2]
        else $error("Interrupt not dropped on matching completion pointer.");
    a_send_owned: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        o_tx_valid |-> word3.sop && word3.owner) // [RULE9]
        else $error("Message sent from a descriptor the port does not own.");
    a_tx_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_msg)) // [RULE19]
        else $error("Transmit request dropped before acceptance.");
    c_chain_two: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        back_ack && !stop_walk ##[1:40] back_ack && chain_end);
    c_teardown: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        o_teardown_done);
    c_irq_ack: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        o_tx_irq ##1 !o_tx_irq);
endmodule

/* File: bench/mem_tx_model.sv */
// Model of the descriptor memory and the message transmit path beside the queue engine.
`timescale 1ns/1ps
module mem_tx_model (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_slow,
    input wire logic i_mem_req,
    input wire logic i_mem_we,
    input wire logic [31:0] i_mem_addr,
    input wire logic [31:0] i_mem_wdata,
    output logic o_mem_ack,
    output logic [31:0] o_mem_rdata,
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    output logic o_tx_done
);
    logic [31:0] mem [0:127];
    logic [2:0] dly;
    logic [2:0] tx_cnt;
    wire logic [6:0] idx = i_mem_addr[8:2];
    // A slow memory makes the engine hold its request for several cycles.
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mem_ack <= 1'b0;
            o_mem_rdata <= 32'h5A5A_5A5A;
            dly <= 3'h0;
        end else if (i_mem_req && !o_mem_ack && dly >= (i_slow ? 3'h3 : 3'h0)) begin
            o_mem_ack <= 1'b1;
            dly <= 3'h0;
            o_mem_rdata <= mem[idx];
            if (i_mem_we) mem[idx] <= i_mem_wdata;
        end else begin
            o_mem_ack <= 1'b0;
            dly <= i_mem_req ? dly + 3'h1 : 3'h0;
            // Stale read data is inverted each cycle, so it returns to the last good word every other cycle.
            o_mem_rdata <= ~o_mem_rdata;
        end
    end
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tx_ready <= 1'b0;
            o_tx_done <= 1'b0;
            tx_cnt <= 3'h0;
        end else begin
            o_tx_ready <= i_tx_valid && !o_tx_ready && tx_cnt == 3'h0;
            o_tx_done <= tx_cnt == 3'h3;
            if (o_tx_ready && i_tx_valid) tx_cnt <= 3'h1;
            else if (tx_cnt != 3'h0) tx_cnt <= (tx_cnt == 3'h3) ? 3'h0 : tx_cnt + 3'h1;
        end
    end
endmodule

/* File: bench/test_tx_message_descriptor_queue.sv */
// Self-checking testbench of the transmit descriptor queue engine.
`timescale 1ns/1ps
module test_tx_message_descriptor_queue;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, tdn = 1'b0, slow = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000, rd, rdata, maddr, mwdata, mrdata;
    logic err, tdone, irq, mreq, mwe, mack, tvalid, tready, tdone_in;
    tx_queue_pkg::tx_msg_t msg;
    int checks = 0, n_fail = 0, nmsg = 0, nerr = 0, ntd = 0;
    logic [31:0] bufs [0:7];
    logic [31:0] last_route = 32'h0000_0000;
    logic [7:0] last_len = 8'h00;
    always #25 clk = ~clk;
    tx_message_descriptor_queue dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_teardown(tdn),
        .o_head_write_err(err), .o_teardown_done(tdone), .o_tx_irq(irq), .o_mem_req(mreq),
        .o_mem_we(mwe), .o_mem_addr(maddr), .o_mem_wdata(mwdata), .i_mem_ack(mack),
        .i_mem_rdata(mrdata), .o_tx_valid(tvalid), .o_tx_msg(msg), .i_tx_ready(tready),
        .i_tx_done(tdone_in));
    mem_tx_model m (.i_sys_clk(clk), .i_rst_n(rst_n), .i_slow(slow), .i_mem_req(mreq),
        .i_mem_we(mwe), .i_mem_addr(maddr), .i_mem_wdata(mwdata), .o_mem_ack(mack),
        .o_mem_rdata(mrdata), .i_tx_valid(tvalid), .o_tx_ready(tready), .o_tx_done(tdone_in));
    always @(posedge clk) begin
        if (tvalid === 1'b1 && tready === 1'b1) begin
            bufs[nmsg[2:0]] <= msg.buf_addr;
            last_route <= msg.route;
            last_len <= msg.msg_len;
            nmsg <= nmsg + 1;
        end
        if (err === 1'b1) nerr <= nerr + 1;
        if (tdone === 1'b1) ntd <= ntd + 1;
    end
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        #1 d = rdata;
    endtask
    // Polls the head pointer until the engine has emptied the queue.
    task automatic head_idle();
        int i;
        for (i = 0; i < 100; i++) begin
            reg_rd(tx_queue_pkg::HEAD_PTR_OFS, rd);
            if (rd === 32'h0000_0000) break;
        end
    endtask
    // Builds a fully filled, single-buffer descriptor before the head write.
    task automatic desc(input int a, input logic [31:0] nx, input logic [31:0] bf,
        input logic [31:0] w3);
        m.mem[a / 4] = nx;
        m.mem[a / 4 + 1] = bf;
        m.mem[a / 4 + 2] = 32'h0012_3456;
        m.mem[a / 4 + 3] = w3;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge clk);
        n_fail++;
        conclude();
    end
    initial begin
        desc(32'h40, 32'h80, 32'h1003, 32'hE000_0010);
        desc(32'h80, 32'h0, 32'h2001, 32'hE000_0020);
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        reg_wr(tx_queue_pkg::HEAD_PTR_OFS, 32'h40);
        reg_wr(tx_queue_pkg::HEAD_PTR_OFS, 32'h100);
        reg_rd(tx_queue_pkg::HEAD_PTR_OFS, rd);
        chk(32'h40, rd);
        head_idle();
        chk(32'h0, rd);
        chk(32'h1, nerr);
        chk(32'h2, nmsg);
        chk(32'h1003, bufs[0]);
        chk(32'h2001, bufs[1]);
        chk(32'h0012_3456, last_route);
        chk(32'h20, last_len);
        chk(32'h0, {m.mem[19][29:27], m.mem[19][19:17]});
        chk(32'h10, {m.mem[35][29:27], m.mem[35][19:17]});
        chk(32'h1, irq);
        reg_wr(tx_queue_pkg::DONE_PTR_OFS, 32'h40);
        reg_rd(tx_queue_pkg::DONE_PTR_OFS, rd);
        chk(32'h40, rd);
        chk(32'h1, irq);
        reg_wr(tx_queue_pkg::DONE_PTR_OFS, 32'h80);
        reg_rd(12'h444, rd);
        chk(32'h0, rd);
        chk(32'h0, irq);
        $display("test chain done");
        slow <= 1'b1;
        desc(32'hC0, 32'h0, 32'h3000, 32'hE000_0008);
        // Teardown on an idle, empty queue is dropped, so it must land during the fetch.
        reg_wr(tx_queue_pkg::HEAD_PTR_OFS, 32'hC0);
        @(posedge clk);
        tdn <= 1'b1;
        @(posedge clk);
        tdn <= 1'b0;
        head_idle();
        repeat (4) @(posedge clk);
        chk(32'h1, ntd);
        chk(32'h2, nmsg);
        chk(32'hE, {m.mem[51][29:27], m.mem[51][19:17]});
        $display("test teardown done");
        desc(32'h100, 32'h0, 32'h4000, 32'hC000_0004);
        reg_wr(tx_queue_pkg::HEAD_PTR_OFS, 32'h100);
        head_idle();
        chk(32'h0, rd);
        chk(32'h2, nmsg);
        chk(32'hC000_0004, m.mem[67]);
        $display("test host owned done");
        conclude();
    end
endmodule
